/* File: core/fmd_params.svh */
// offsets, field positions, reset values and widths of the freefall/motion detector
// assumes inclusion by every design file of the block except the package
`ifndef FMD_PARAMS_SVH
`define FMD_PARAMS_SVH

`define FMD_CFG_ADDR      8'h15
`define FMD_SRC_ADDR      8'h16
`define FMD_CFG_RESET     8'h00
`define FMD_SRC_RESET     8'h00
`define FMD_CNT_RESET     8'h00
`define FMD_RDATA_RESET   8'h00
`define FMD_UNMAPPED_DATA 8'h00

`define FMD_CFG_LATCH_BIT 7
`define FMD_CFG_OAE_BIT   6
`define FMD_CFG_Z_BIT     5
`define FMD_CFG_Y_BIT     4
`define FMD_CFG_X_BIT     3

`define FMD_SRC_EA_BIT    7
`define FMD_FLAG_W        6
`define FMD_CNT_W         8
`define FMD_THS_W         7
`define FMD_SAMPLE_W      8

`endif

/* File: core/fmd_pkg.sv */
// types shared by the freefall/motion detector
// assumes nothing beyond a SystemVerilog compiler
package fmd_pkg;

	// operating mode as {event_latch_on, or_and_select}
	typedef enum logic [1:0] {
		FMD_FREEFALL_LIVE  = 2'b00,
		FMD_MOTION_LIVE    = 2'b01,
		FMD_FREEFALL_LATCH = 2'b10,
		FMD_MOTION_LATCH   = 2'b11
	} fmd_mode_t;

	typedef logic [2:0] fmd_axis_t;

endpackage

/* File: core/fmd_axis_cmp.sv */
// one axis of the detector: magnitude against threshold, sign of the sample
// assumes a signed sample already scaled to threshold units
`timescale 1ns/1ps
`include "fmd_params.svh"

module fmd_axis_cmp
	import fmd_pkg::*;
#(
	parameter int SAMPLE_W = `FMD_SAMPLE_W
) (
	input  wire logic signed [SAMPLE_W-1:0]  sample,
	input  wire logic        [`FMD_THS_W-1:0] threshold,
	output logic                              high_g,
	output logic                              low_g,
	output logic                              negative
);

	function automatic logic [SAMPLE_W-1:0] fmd_mag(input logic signed [SAMPLE_W-1:0] s);
		fmd_mag = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
	endfunction

	logic [SAMPLE_W-1:0] mag;

	always_comb begin
		mag      = fmd_mag(sample);
		high_g   = mag > SAMPLE_W'(threshold);
		low_g    = !high_g;
		negative = sample[SAMPLE_W-1];
	end

endmodule

/* File: core/fmd_debounce.sv */
// debounce counter stepped once per output sample
// assumes step is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`include "fmd_params.svh"

module fmd_debounce
	import fmd_pkg::*;
#(
	parameter int CNT_W = `FMD_CNT_W
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic             step,
	input  wire logic             cond,
	input  wire logic             restart,
	input  wire logic             clear_mode,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  reached,
	output logic                  empty
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] base;
	logic             hit;

	function automatic logic [CNT_W-1:0] fmd_sat_inc(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
		fmd_sat_inc = (v < lim) ? v + CNT_W'(1) : v;
	endfunction

	always_comb begin
		// a sample completing the count beats a restart in the same cycle
		hit      = step && cond && (fmd_sat_inc(cnt, limit) >= limit);
		base     = (restart && !hit) ? CNT_W'(`FMD_CNT_RESET) : cnt;
		next_cnt = base;
		if (step) begin
			if (cond) begin
				next_cnt = fmd_sat_inc(base, limit);
			end else if (clear_mode) begin
				next_cnt = CNT_W'(`FMD_CNT_RESET);
			end else if (base != '0) begin
				next_cnt = base - CNT_W'(1);
			end
		end
		reached = hit;
		empty   = next_cnt == '0;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			cnt <= CNT_W'(`FMD_CNT_RESET);
		else
			cnt <= next_cnt;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	cnt_idle_a: assert property (!step && !restart |=> $stable(cnt))
		else $error("debounce counter moved without a sample");

	cnt_clear_a: assert property (step && !cond && clear_mode |=> cnt == '0)
		else $error("debounce counter not cleared in clear mode");

endmodule

/* File: core/fmd_detector.sv */
// freefall/motion event detector with its configuration and source registers
// assumes a register port from the serial interface logic and sample pulses
// at the output data rate, both on sys_clk
`timescale 1ns/1ps
`include "fmd_params.svh"

module fmd_detector
	import fmd_pkg::*;
#(
	parameter int SAMPLE_W = `FMD_SAMPLE_W,
	parameter int CNT_W    = `FMD_CNT_W
) (
	input  wire logic                       sys_clk,
	input  wire logic                       arst_n,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [7:0]                 reg_wdata,
	output logic      [7:0]                 reg_rdata,
	input  wire logic                       sample_valid,
	input  wire logic signed [SAMPLE_W-1:0] x_sample,
	input  wire logic signed [SAMPLE_W-1:0] y_sample,
	input  wire logic signed [SAMPLE_W-1:0] z_sample,
	input  wire logic [`FMD_THS_W-1:0]      motion_threshold,
	input  wire logic                       debounce_clear_mode,
	input  wire logic [CNT_W-1:0]           motion_debounce_count,
	output logic                            event_active,
	output logic      [7:0]                 motion_source_reg
);

	// configuration register
	logic [4:0] cfg;
	logic [4:0] next_cfg;

	// source register state
	logic                   ea;
	logic                   next_ea;
	logic [`FMD_FLAG_W-1:0] flags;
	logic [`FMD_FLAG_W-1:0] next_flags;
	logic [7:0]             next_rdata;

	logic                   event_latch_on;
	logic                   or_and_select;
	fmd_axis_t              axis_on;
	fmd_mode_t              mode;
	logic                   any_on;
	logic                   latched;
	logic                   src_read;
	logic                   latch_clear;
	logic                   ea_base;
	logic [`FMD_FLAG_W-1:0] flags_base;

	fmd_axis_t              high_g;
	fmd_axis_t              low_g;
	fmd_axis_t              negative;
	logic [`FMD_FLAG_W-1:0] raw_flags;
	logic [`FMD_FLAG_W-1:0] flag_mask;
	logic                   cond;
	logic                   db_reached;
	logic                   db_empty;
	logic                   db_restart;

	// cfg keeps only bits 7:3 of the configuration register
	assign event_latch_on = cfg[`FMD_CFG_LATCH_BIT-`FMD_CFG_X_BIT];
	assign or_and_select  = cfg[`FMD_CFG_OAE_BIT-`FMD_CFG_X_BIT];
	assign axis_on        = cfg[`FMD_CFG_Z_BIT-`FMD_CFG_X_BIT:0];

	// per-axis comparators, x in bit 0, z in bit 2
	fmd_axis_cmp #(
		.SAMPLE_W (SAMPLE_W)
	) u_x (
		.sample    (x_sample),
		.threshold (motion_threshold),
		.high_g    (high_g[0]),
		.low_g     (low_g[0]),
		.negative  (negative[0])
	);

	fmd_axis_cmp #(
		.SAMPLE_W (SAMPLE_W)
	) u_y (
		.sample    (y_sample),
		.threshold (motion_threshold),
		.high_g    (high_g[1]),
		.low_g     (low_g[1]),
		.negative  (negative[1])
	);

	fmd_axis_cmp #(
		.SAMPLE_W (SAMPLE_W)
	) u_z (
		.sample    (z_sample),
		.threshold (motion_threshold),
		.high_g    (high_g[2]),
		.low_g     (low_g[2]),
		.negative  (negative[2])
	);

	// mode decode and the combined condition
	always_comb begin
		mode = fmd_mode_t'({event_latch_on, or_and_select});
		any_on = |axis_on;
		case (mode)
			FMD_FREEFALL_LATCH,
			FMD_MOTION_LATCH: latched = 1'b1;
			FMD_FREEFALL_LIVE,
			FMD_MOTION_LIVE: latched = 1'b0;
			default: latched = 1'b0;
		endcase
		// AND for freefall, OR for motion
		if (!any_on)
			cond = 1'b0;
		else if (or_and_select)
			cond = |(high_g & axis_on);
		else
			cond = &(low_g | ~axis_on);
		// raw status per axis, high-g above polarity
		raw_flags = {high_g[2], negative[2], high_g[1], negative[1], high_g[0], negative[0]};
		flag_mask = {{2{axis_on[2]}}, {2{axis_on[1]}}, {2{axis_on[0]}}};
		src_read  = reg_rd && (reg_addr == `FMD_SRC_ADDR);
		// nothing cleared on a live read
		latch_clear = src_read && latched;
		db_restart = latch_clear || !any_on;
	end

	fmd_debounce #(
		.CNT_W (CNT_W)
	) u_db (
		.sys_clk    (sys_clk),
		.arst_n     (arst_n),
		.step       (sample_valid),
		.cond       (cond),
		.restart    (db_restart),
		.clear_mode (debounce_clear_mode),
		.limit      (motion_debounce_count),
		.reached    (db_reached),
		.empty      (db_empty)
	);

	// event flag and axis flags; a read in the same cycle as an event loses to it
	always_comb begin
		// set wins: a completing sample during a latched read still sets the event
		// latched read clears the event
		ea_base    = latch_clear ? 1'b0 : ea;
		flags_base = latch_clear ? '0 : flags;
		next_ea    = ea_base;
		next_flags = flags_base;
		if (!any_on) begin
			next_ea    = 1'b0;
			next_flags = '0;
		end else begin
			// set at count, held if latched
			if (db_reached)
				next_ea = 1'b1;
			// live clear at once in clear mode
			else if (!latched && sample_valid && !cond && (debounce_clear_mode || db_empty))
				next_ea = 1'b0;
			// flags hold while latched event set
			if (sample_valid && !(latched && ea_base))
				next_flags = raw_flags;
		end
	end

	// register port
	// a write and a read in one cycle: the read returns the old value
	always_comb begin
		next_cfg   = cfg;
		next_rdata = reg_rdata;
		if (reg_wr && (reg_addr == `FMD_CFG_ADDR))
			next_cfg = reg_wdata[`FMD_CFG_LATCH_BIT:`FMD_CFG_X_BIT];
		if (reg_rd) begin
			case (reg_addr)
				`FMD_CFG_ADDR: next_rdata = {cfg, 3'h0};
				`FMD_SRC_ADDR: next_rdata = motion_source_reg;
				default: next_rdata = `FMD_UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg       <= 5'(`FMD_CFG_RESET >> `FMD_CFG_X_BIT);
			ea        <= 1'(`FMD_SRC_RESET >> `FMD_SRC_EA_BIT);
			flags     <= 6'(`FMD_SRC_RESET);
			reg_rdata <= `FMD_RDATA_RESET;
		end else begin
			cfg       <= next_cfg;
			ea        <= next_ea;
			flags     <= next_flags;
			reg_rdata <= next_rdata;
		end
	end

	assign event_active      = ea;
	assign motion_source_reg = {ea, 1'b0, flags & flag_mask};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	sequence latch_rd_s;
		event_latch_on && src_read && !sample_valid;
	endsequence

	sequence live_rd_s;
		!event_latch_on && src_read && !sample_valid && !reg_wr;
	endsequence

	sequence frozen_s;
		event_latch_on && event_active && !src_read && any_on;
	endsequence

	// latched read, an idle cycle, then a sample that cannot complete the count
	sequence relatch_s;
		latch_rd_s ##1 !sample_valid ##1 (sample_valid && motion_debounce_count > CNT_W'(1));
	endsequence

	off_idle_a: assert property (axis_on == 3'h0 |=> !event_active && motion_source_reg == 8'h00)
		else $error("detector active with all axes disabled");

	freefall_and_a: assert property (any_on && !or_and_select |-> cond == !(|(high_g & axis_on)))
		else $error("freefall condition is not the AND of enabled axes");

	motion_or_a: assert property (any_on && or_and_select |-> cond ==
		((axis_on[0] && high_g[0]) || (axis_on[1] && high_g[1]) || (axis_on[2] && high_g[2])))
		else $error("motion condition is not the OR of enabled axes");

	ea_rise_a: assert property ($rose(event_active) |-> $past(db_reached))
		else $error("event set before debounce count completed");

	ea_hold_a: assert property (frozen_s |=> event_active)
		else $error("latched event dropped without a source read");

	latch_clear_a: assert property (latch_rd_s |=> !event_active && motion_source_reg == 8'h00)
		else $error("latched source read did not clear the register");

	live_read_a: assert property (live_rd_s |=> $stable(motion_source_reg))
		else $error("non-latched source read changed the source register");

	flag_freeze_a: assert property (frozen_s |=> $stable(motion_source_reg[5:0]))
		else $error("axis flags moved while latched event set");

	flag_live_a: assert property (sample_valid && !latched && any_on
		|=> motion_source_reg[5:0] == $past(raw_flags & flag_mask))
		else $error("live axis flags do not follow raw status");

	fast_clear_a: assert property (!latched && debounce_clear_mode && sample_valid && any_on && !cond
		|=> !event_active)
		else $error("event not cleared at once in clear mode");

	slow_clear_a: assert property ($fell(event_active) && !$past(latched) && !$past(debounce_clear_mode)
		&& $past(any_on) |-> $past(db_empty))
		else $error("event cleared before counter ran down");

	relatch_wait_a: assert property (relatch_s |-> !db_reached)
		else $error("event re-armed before the full debounce delay");

	src_rdata_a: assert property (src_read |=> reg_rdata == $past(motion_source_reg))
		else $error("source read returned a value other than the register");

	cfg_rdata_a: assert property (reg_rd && reg_addr == `FMD_CFG_ADDR |=> reg_rdata[2:0] == 3'h0)
		else $error("unused configuration bits read as nonzero");

	off_axis_a: assert property ((axis_on[0] || motion_source_reg[1:0] == 2'h0)
		&& (axis_on[1] || motion_source_reg[3:2] == 2'h0)
		&& (axis_on[2] || motion_source_reg[5:4] == 2'h0))
		else $error("disabled axis shows a nonzero flag");

endmodule

/* File: test/fmd_host_model.sv */
// host side of the register port: one-cycle write and read strobes
// assumes the detector's register port on sys_clk, answer one cycle after the read edge
`timescale 1ns/1ps

module fmd_host_model (
	input  wire logic       sys_clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// released lines carry junk, not the last value
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

/* File: test/test_fmd_detector.sv */
// self-checking bench for the freefall/motion detector
// assumes the host model for register access and a bench-driven sample stream
`timescale 1ns/1ps
`include "fmd_params.svh"

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module test_fmd_detector;
	import fmd_pkg::*;
	logic              sys_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic        [7:0] reg_addr, reg_wdata, reg_rdata, motion_source_reg;
	logic              reg_wr, reg_rd, event_active;
	logic              sample_valid = 1'b0;
	logic signed [7:0] x_sample = 8'sh00, y_sample = 8'sh00, z_sample = 8'sh00;
	logic        [6:0] motion_threshold = 7'h0a;
	logic              debounce_clear_mode = 1'b1;
	logic        [7:0] motion_debounce_count = 8'h02;
	int                error_cnt = 0;
	int                checks_done = 0;
	int                cyc = 0;

	always #10 sys_clk = ~sys_clk;

	fmd_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	fmd_detector u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample), .motion_threshold(motion_threshold),
		.debounce_clear_mode(debounce_clear_mode), .motion_debounce_count(motion_debounce_count),
		.event_active(event_active), .motion_source_reg(motion_source_reg));

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one sample, then source and event checked one cycle later
	task automatic smp(input logic signed [7:0] x, input logic signed [7:0] y, input logic signed [7:0] z,
		input logic [7:0] e);
		@(posedge sys_clk);
		x_sample <= x;
		y_sample <= y;
		z_sample <= z;
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		#1;
		`CHK("source", e, motion_source_reg)
		`CHK("event", e[7], event_active)
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		`CHK("rdata", e, d)
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		chk_rd(`FMD_CFG_ADDR, 8'h00);
		chk_rd(`FMD_SRC_ADDR, 8'h00);
		chk_rd(8'h40, 8'h00);
		u_host.wr(`FMD_CFG_ADDR, 8'hff);
		chk_rd(`FMD_CFG_ADDR, 8'hf8);
		$display("test registers done");
		// motion, live, x only
		u_host.wr(`FMD_CFG_ADDR, 8'h48);
		smp(8'sd20, 8'sd90, 8'sd0, 8'h02);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h82);
		chk_rd(`FMD_SRC_ADDR, 8'h82);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h82);
		smp(8'sd10, 8'sd0, 8'sd0, 8'h00);
		smp(-8'sd20, 8'sd0, 8'sd0, 8'h03);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h00);
		$display("test motion live done");
		// motion, latched
		u_host.wr(`FMD_CFG_ADDR, 8'hc8);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h02);
		smp(-8'sd20, 8'sd0, 8'sd0, 8'h83);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h83);
		chk_rd(`FMD_SRC_ADDR, 8'h83);
		#1;
		`CHK("source", 8'h00, motion_source_reg)
		smp(8'sd20, 8'sd0, 8'sd0, 8'h02);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h82);
		chk_rd(`FMD_SRC_ADDR, 8'h82);
		$display("test motion latched done");
		// freefall, live, decrement mode
		u_host.wr(`FMD_CFG_ADDR, 8'h38);
		debounce_clear_mode <= 1'b0;
		smp(8'sd0, 8'sd3, -8'sd3, 8'h10);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h80);
		chk_rd(`FMD_SRC_ADDR, 8'h80);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h82);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h02);
		// freefall, live, clear mode
		@(posedge sys_clk);
		debounce_clear_mode <= 1'b1;
		smp(8'sd0, 8'sd0, 8'sd0, 8'h00);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h80);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h02);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h00);
		smp(8'sd20, 8'sd0, 8'sd0, 8'h02);
		$display("test freefall live done");
		// freefall, latched: flags frozen until a source read
		u_host.wr(`FMD_CFG_ADDR, 8'hb8);
		debounce_clear_mode <= 1'b1;
		smp(8'sd0, 8'sd0, 8'sd0, 8'h00);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h80);
		smp(8'sd30, 8'sd0, 8'sd0, 8'h80);
		chk_rd(`FMD_SRC_ADDR, 8'h80);
		smp(8'sd30, 8'sd0, 8'sd0, 8'h02);
		// all axes off
		u_host.wr(`FMD_CFG_ADDR, 8'h80);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h00);
		smp(8'sd0, 8'sd0, 8'sd0, 8'h00);
		$display("test freefall latched done");
		conclude();
	end
endmodule
